// ===== flag_bank.sv
// Module: one 8-bit bank of hardware-set, software-written flags
module flag_bank #(
  parameter logic [7:0] IMPL = 8'hff
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Flag path
  flag_bus_if.bank fb
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // Event set beats a same-cycle software write of zero
  always_comb begin
    flags_d = flags_q;
    if (fb.wrEn) begin
      flags_d = fb.wrData;
    end
    flags_d = (flags_d | fb.setEv) & IMPL;
  end

  // Flag storage, cleared on any reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= pir_pkg::RST_FLAGS;
    end else if (ce) begin
      flags_q <= flags_d;
    end
  end

  assign fb.flags = flags_q;

  property p_set_wins;
    @(posedge clk) disable iff (rst)
      (ce && (fb.setEv & IMPL) != 8'h00) |=>
        ((flags_q & $past(fb.setEv & IMPL)) == $past(fb.setEv & IMPL));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost in flag bank");

  property p_unimpl_zero;
    @(posedge clk) disable iff (rst) (flags_q & ~IMPL) == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented flag bit set");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (!ce) |=> $stable(flags_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flags changed while frozen");
endmodule

// ===== flag_bus_if.sv
// Interface: write/clear path between top and flag bank
interface flag_bus_if;
  logic [7:0] setEv;
  logic wrEn;
  logic [7:0] wrData;
  logic [7:0] flags;
  modport bank (input setEv, input wrEn, input wrData, output flags);
  modport ctrl (output setEv, output wrEn, output wrData, input flags);
endinterface

// ===== periph_irq_flags.sv
// Top: peripheral interrupt request flag registers two and three
// Overview of operation
// - Events set flags regardless of enables
// - Flag reads one pending, zero otherwise
// - Register two bits: osc,cmp2,cmp1,nv,coll,cc2
// - Unimplemented bits always read zero
// - Register three bit5 cc4, bit4 cc3
// - Register three bit3 timer6, bit1 timer4
// - Flags writable, cleared by every reset
// - Register three, cc2 only large variant
// - No periphIrq without peripheral enable; irq follows unmasked sticky status
//
// The implementer's own choices: the address map and the strobed register port.
module periph_irq_flags #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  // Event sources, one-cycle pulses on clk
  input wire logic oscFailEv,
  input wire logic cmpTwoEv,
  input wire logic cmpOneEv,
  input wire logic nvWriteDoneEv,
  input wire logic serialOneCollEv,
  input wire logic capcompTwoEv,
  input wire logic capcompThreeEv,
  input wire logic capcompFourEv,
  input wire logic timerSixMatchEv,
  input wire logic timerFourMatchEv,
  // Outputs
  output logic periphIrq,
  output logic irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam logic [7:0] IMPL_TWO = LARGE_VARIANT ?
    pir_pkg::MASK_TWO_BIG : pir_pkg::MASK_TWO_SMALL;
  localparam logic [7:0] IMPL_THREE = LARGE_VARIANT ?
    pir_pkg::MASK_THREE : 8'h00;

  flag_bus_if fbTwo ();
  flag_bus_if fbThree ();

  logic [7:0] enTwo_q;
  logic [7:0] enThree_q;
  logic [7:0] coreCtrl_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [7:0] rdData_q;
  logic periphIrq_q;
  logic irq_q;
  logic reqNow;
  logic reqPrev_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------
  // Flag banks
  // ----------------------------------------
  // Event vector for register two
  always_comb begin
    fbTwo.setEv = 8'h00;
    fbTwo.setEv[pir_pkg::BIT_OSC_FAIL] = oscFailEv;
    fbTwo.setEv[pir_pkg::BIT_CMP_TWO] = cmpTwoEv;
    fbTwo.setEv[pir_pkg::BIT_CMP_ONE] = cmpOneEv;
    fbTwo.setEv[pir_pkg::BIT_NV_DONE] = nvWriteDoneEv;
    fbTwo.setEv[pir_pkg::BIT_SER_COLL] = serialOneCollEv;
    fbTwo.setEv[pir_pkg::BIT_CAPCOMP_TWO] = capcompTwoEv;
  end

  // Event vector for register three
  always_comb begin
    fbThree.setEv = 8'h00;
    fbThree.setEv[pir_pkg::BIT_CAPCOMP_FOUR] = capcompFourEv;
    fbThree.setEv[pir_pkg::BIT_CAPCOMP_THREE] = capcompThreeEv;
    fbThree.setEv[pir_pkg::BIT_TIMER_SIX] = timerSixMatchEv;
    fbThree.setEv[pir_pkg::BIT_TIMER_FOUR] = timerFourMatchEv;
  end

  // Software writes reach the banks
  assign fbTwo.wrEn = wrStb && hit(addr, pir_pkg::OFF_REQ_TWO);
  assign fbTwo.wrData = wrData;
  assign fbThree.wrEn = wrStb && hit(addr, pir_pkg::OFF_REQ_THREE);
  assign fbThree.wrData = wrData;

  flag_bank #(.IMPL(IMPL_TWO)) bankTwo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .fb(fbTwo)
  );

  flag_bank #(.IMPL(IMPL_THREE)) bankThree (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .fb(fbThree)
  );

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Enables and core control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enTwo_q <= pir_pkg::RST_FLAGS;
      enThree_q <= pir_pkg::RST_FLAGS;
      coreCtrl_q <= pir_pkg::RST_FLAGS;
    end else if (ce && wrStb) begin
      if (hit(addr, pir_pkg::OFF_EN_TWO)) begin
        enTwo_q <= wrData & IMPL_TWO;
      end
      if (hit(addr, pir_pkg::OFF_EN_THREE)) begin
        enThree_q <= wrData & IMPL_THREE;
      end
      if (hit(addr, pir_pkg::OFF_CORE_CTRL)) begin
        coreCtrl_q <= wrData & pir_pkg::MASK_CORE;
      end
    end
  end

  // ----------------------------------------
  // Request generation
  // ----------------------------------------
  // Any enabled flag, gated by peripheral and global enables
  assign reqNow = (|(fbTwo.flags & enTwo_q) ||
                   |(fbThree.flags & enThree_q)) &&
                  coreCtrl_q[pir_pkg::BIT_PERIPH_EN] &&
                  coreCtrl_q[pir_pkg::BIT_GLOBAL_EN];

  // Registered request and edge tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periphIrq_q <= 1'b0;
      reqPrev_q <= 1'b0;
    end else if (ce) begin
      periphIrq_q <= reqNow;
      reqPrev_q <= reqNow;
    end
  end

  // Sticky status: rise and fall of request; write one clears, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= 2'h0;
      mask_q <= 2'h0;
    end else if (ce) begin
      stat_q <= (stat_q & ~((wrStb && hit(addr, pir_pkg::OFF_IRQ_STAT)) ?
                 wrData[1:0] : 2'h0)) |
                ((reqNow && !reqPrev_q) ? pir_pkg::STAT_RISE : 2'h0) |
                ((!reqNow && reqPrev_q) ? pir_pkg::STAT_FALL : 2'h0);
      if (wrStb && hit(addr, pir_pkg::OFF_IRQ_MASK)) begin
        mask_q <= wrData[1:0];
      end
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (ce) begin
      rdData_q <= 8'h00;
      if (rdStb) begin
        case (addr)
          pir_pkg::OFF_REQ_TWO: rdData_q <= fbTwo.flags;
          pir_pkg::OFF_REQ_THREE: rdData_q <= fbThree.flags;
          pir_pkg::OFF_EN_TWO: rdData_q <= enTwo_q;
          pir_pkg::OFF_EN_THREE: rdData_q <= enThree_q;
          pir_pkg::OFF_CORE_CTRL: rdData_q <= coreCtrl_q;
          pir_pkg::OFF_IRQ_STAT: rdData_q <= {6'h00, stat_q};
          pir_pkg::OFF_IRQ_MASK: rdData_q <= {6'h00, mask_q};
          default: rdData_q <= 8'h00;
        endcase
      end
    end
  end

  assign rdData = rdData_q;
  assign periphIrq = periphIrq_q;
  assign irq = irq_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_no_periph_en;
    @(posedge clk) disable iff (rst)
      (!coreCtrl_q[pir_pkg::BIT_PERIPH_EN] && $stable(coreCtrl_q)) |=>
        !periphIrq_q;
  endproperty
  a_no_periph_en: assert property (p_no_periph_en)
    else $error("request without peripheral enable");

  property p_req;
    @(posedge clk) disable iff (rst)
      (ce && (fbTwo.flags & enTwo_q) != 8'h00 &&
       coreCtrl_q == pir_pkg::MASK_CORE) |=> periphIrq_q;
  endproperty
  a_req: assert property (p_req)
    else $error("enabled flag raised no request");

  property p_set_indep;
    @(posedge clk) disable iff (rst)
      (ce && oscFailEv) |=> fbTwo.flags[pir_pkg::BIT_OSC_FAIL];
  endproperty
  a_set_indep: assert property (p_set_indep)
    else $error("event did not set flag");

  property p_map_three;
    @(posedge clk) disable iff (rst)
      (ce && timerFourMatchEv && LARGE_VARIANT) |=>
        fbThree.flags[pir_pkg::BIT_TIMER_FOUR];
  endproperty
  a_map_three: assert property (p_map_three)
    else $error("timer four flag missing");

  property p_cc4;
    @(posedge clk) disable iff (rst)
      (ce && capcompFourEv && LARGE_VARIANT) |=>
        fbThree.flags[pir_pkg::BIT_CAPCOMP_FOUR];
  endproperty
  a_cc4: assert property (p_cc4)
    else $error("capcomp four flag missing");

  property p_map_two;
    @(posedge clk) disable iff (rst)
      (ce && serialOneCollEv) |=> fbTwo.flags[pir_pkg::BIT_SER_COLL];
  endproperty
  a_map_two: assert property (p_map_two)
    else $error("collision flag missing");

  property p_map_six;
    @(posedge clk) disable iff (rst)
      (ce && timerSixMatchEv && LARGE_VARIANT) |=>
        fbThree.flags[pir_pkg::BIT_TIMER_SIX];
  endproperty
  a_map_six: assert property (p_map_six)
    else $error("timer six flag missing");

  property p_wr_load;
    @(posedge clk) disable iff (rst)
      (ce && wrStb && addr == pir_pkg::OFF_REQ_TWO &&
       fbTwo.setEv == 8'h00) |=> fbTwo.flags == ($past(wrData) & IMPL_TWO);
  endproperty
  a_wr_load: assert property (p_wr_load)
    else $error("write to register two lost");

  property p_rd_two;
    @(posedge clk) disable iff (rst)
      (ce && rdStb && addr == pir_pkg::OFF_REQ_TWO) |=>
        rdData == $past(fbTwo.flags);
  endproperty
  a_rd_two: assert property (p_rd_two)
    else $error("read of register two wrong");

  property p_rd_zero;
    @(posedge clk) disable iff (rst)
      (ce && rdStb && addr == pir_pkg::OFF_REQ_THREE) |=>
        (rdData & ~IMPL_THREE) == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("unimplemented bit read as one");

  property p_small;
    @(posedge clk) disable iff (rst)
      !LARGE_VARIANT |-> fbThree.flags == 8'h00;
  endproperty
  a_small: assert property (p_small)
    else $error("register three present in small variant");

  property p_irq;
    @(posedge clk) disable iff (rst)
      (ce && (stat_q & mask_q) != 2'h0) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output missing");

  c_req: cover property (@(posedge clk) disable iff (rst)
    !periphIrq_q ##1 periphIrq_q);
  c_clear: cover property (@(posedge clk) disable iff (rst)
    fbTwo.flags[pir_pkg::BIT_SER_COLL] ##1
    !fbTwo.flags[pir_pkg::BIT_SER_COLL]);
  c_race: cover property (@(posedge clk) disable iff (rst)
    fbTwo.wrEn && !fbTwo.wrData[pir_pkg::BIT_OSC_FAIL] && oscFailEv);
  c_irq: cover property (@(posedge clk) disable iff (rst) irq_q);
endmodule

// ===== pir_pkg.sv
// Package: offsets, bit positions, reset values for the flag block
package pir_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFF_REQ_TWO = 4'h0;
  localparam logic [3:0] OFF_REQ_THREE = 4'h1;
  localparam logic [3:0] OFF_EN_TWO = 4'h2;
  localparam logic [3:0] OFF_EN_THREE = 4'h3;
  localparam logic [3:0] OFF_CORE_CTRL = 4'h4;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h5;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
  // ----------------------------------------
  // Bit positions, request register two
  // ----------------------------------------
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_CMP_TWO = 6;
  localparam int BIT_CMP_ONE = 5;
  localparam int BIT_NV_DONE = 4;
  localparam int BIT_SER_COLL = 3;
  localparam int BIT_CAPCOMP_TWO = 0;
  // ----------------------------------------
  // Bit positions, request register three
  // ----------------------------------------
  localparam int BIT_CAPCOMP_FOUR = 5;
  localparam int BIT_CAPCOMP_THREE = 4;
  localparam int BIT_TIMER_SIX = 3;
  localparam int BIT_TIMER_FOUR = 1;
  // Core control bits
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_EN = 6;
  // ----------------------------------------
  // Implemented masks and reset values
  // ----------------------------------------
  localparam logic [7:0] MASK_TWO_BIG = 8'hf9;
  localparam logic [7:0] MASK_TWO_SMALL = 8'hf8;
  localparam logic [7:0] MASK_THREE = 8'h3a;
  localparam logic [7:0] MASK_CORE = 8'hc0;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [1:0] STAT_RISE = 2'h1;
  localparam logic [1:0] STAT_FALL = 2'h2;
endpackage

// ===== tb.sv
// Testbench: self-checking bench for the peripheral flag registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and design hookup
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [7:0] rdData;
  logic [9:0] evs = 10'h000;
  logic periphIrq;
  logic irq;
  logic [7:0] rdDataSmall;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] m2, m3, d, got;
  logic [9:0] e;
  // Free-running 50 MHz clock
  always #10 clk = ~clk;
  periph_irq_flags #(.LARGE_VARIANT(1'b1)) i_dut (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .oscFailEv(evs[0]), .cmpTwoEv(evs[1]), .cmpOneEv(evs[2]),
    .nvWriteDoneEv(evs[3]), .serialOneCollEv(evs[4]),
    .capcompTwoEv(evs[5]), .capcompThreeEv(evs[6]),
    .capcompFourEv(evs[7]), .timerSixMatchEv(evs[8]),
    .timerFourMatchEv(evs[9]), .periphIrq(periphIrq), .irq(irq));
  // Small variant without register three and bit 0 of register two
  periph_irq_flags #(.LARGE_VARIANT(1'b0)) i_dutSmall (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdDataSmall),
    .oscFailEv(evs[0]), .cmpTwoEv(evs[1]), .cmpOneEv(evs[2]),
    .nvWriteDoneEv(evs[3]), .serialOneCollEv(evs[4]),
    .capcompTwoEv(evs[5]), .capcompThreeEv(evs[6]),
    .capcompFourEv(evs[7]), .timerSixMatchEv(evs[8]),
    .timerFourMatchEv(evs[9]), .periphIrq(), .irq());
  // ----------------------------------------
  // Expectation functions and shared tasks
  // ----------------------------------------
  // Event vector to register two image
  function automatic logic [7:0] two_of(logic [9:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[pir_pkg::BIT_OSC_FAIL] = v[0];
    r[pir_pkg::BIT_CMP_TWO] = v[1];
    r[pir_pkg::BIT_CMP_ONE] = v[2];
    r[pir_pkg::BIT_NV_DONE] = v[3];
    r[pir_pkg::BIT_SER_COLL] = v[4];
    r[pir_pkg::BIT_CAPCOMP_TWO] = v[5];
    return r;
  endfunction
  // Event vector to register three image
  function automatic logic [7:0] three_of(logic [9:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[pir_pkg::BIT_CAPCOMP_THREE] = v[6];
    r[pir_pkg::BIT_CAPCOMP_FOUR] = v[7];
    r[pir_pkg::BIT_TIMER_SIX] = v[8];
    r[pir_pkg::BIT_TIMER_FOUR] = v[9];
    return r;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wrData <= v;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 v = rdData;
  endtask
  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    evs <= v;
    @(posedge clk);
    evs <= 10'h000;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial begin
    #(20 * 20000);
    num_errors++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1462c0e8));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // All registers clear after reset
    for (int i = 0; i < 7; i++) begin
      rd(i[3:0], got);
      chk(got, 8'h00);
    end
    // Each source lands on its own bit, with enables off
    for (int i = 0; i < 10; i++) begin
      pulse(10'h001 << i);
      rd(pir_pkg::OFF_REQ_TWO, got);
      chk(got, two_of(10'h001 << i));
      chk(rdDataSmall, two_of(10'h001 << i) & 8'hf8);
      rd(pir_pkg::OFF_REQ_THREE, got);
      chk(got, three_of(10'h001 << i));
      chk(rdDataSmall, 8'h00);
      wr(pir_pkg::OFF_REQ_TWO, 8'h00);
      wr(pir_pkg::OFF_REQ_THREE, 8'h00);
      rd(pir_pkg::OFF_REQ_TWO, got);
      chk(got, 8'h00);
    end
    // Unimplemented bits read zero, unmapped place ignored
    wr(pir_pkg::OFF_REQ_TWO, 8'hff);
    wr(pir_pkg::OFF_REQ_THREE, 8'hff);
    wr(4'hf, 8'hff);
    rd(pir_pkg::OFF_REQ_TWO, got);
    chk(got, 8'hf9);
    chk(rdDataSmall, 8'hf8);
    rd(pir_pkg::OFF_REQ_THREE, got);
    chk(got, 8'h3a);
    chk(rdDataSmall, 8'h00);
    rd(4'hf, got);
    chk(got, 8'h00);
    // Event in the same cycle as a clearing write survives
    @(posedge clk);
    addr <= pir_pkg::OFF_REQ_TWO;
    wrData <= 8'h00;
    wrStb <= 1'b1;
    evs <= 10'h001;
    @(posedge clk);
    wrStb <= 1'b0;
    evs <= 10'h000;
    rd(pir_pkg::OFF_REQ_TWO, got);
    chk(got, 8'h80);
    // Request gating by enables, status and interrupt line
    wr(pir_pkg::OFF_IRQ_MASK, 8'h01);
    wr(pir_pkg::OFF_REQ_TWO, 8'h00);
    wr(pir_pkg::OFF_EN_TWO, 8'h80);
    pulse(10'h001);
    wr(pir_pkg::OFF_CORE_CTRL, 8'h80);
    settle();
    chk({7'h00, periphIrq}, 8'h00);
    wr(pir_pkg::OFF_CORE_CTRL, 8'h40);
    settle();
    chk({7'h00, periphIrq}, 8'h00);
    wr(pir_pkg::OFF_CORE_CTRL, 8'hff);
    rd(pir_pkg::OFF_CORE_CTRL, got);
    chk(got, 8'hc0);
    settle();
    chk({7'h00, periphIrq}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rd(pir_pkg::OFF_IRQ_STAT, got);
    chk(got, 8'h01);
    wr(pir_pkg::OFF_REQ_TWO, 8'h00);
    settle();
    chk({7'h00, periphIrq}, 8'h00);
    rd(pir_pkg::OFF_IRQ_STAT, got);
    chk(got, 8'h03);
    wr(pir_pkg::OFF_IRQ_MASK, 8'h00);
    settle();
    chk({7'h00, irq}, 8'h00);
    wr(pir_pkg::OFF_IRQ_MASK, 8'h02);
    settle();
    chk({7'h00, irq}, 8'h01);
    wr(pir_pkg::OFF_IRQ_STAT, 8'h03);
    settle();
    chk({7'h00, irq}, 8'h00);
    rd(pir_pkg::OFF_IRQ_STAT, got);
    chk(got, 8'h00);
    // Register three feeds the same request
    wr(pir_pkg::OFF_EN_THREE, 8'hff);
    rd(pir_pkg::OFF_EN_THREE, got);
    chk(got, 8'h3a);
    settle();
    chk({7'h00, periphIrq}, 8'h01);
    // Random events mixed with random loads
    wr(pir_pkg::OFF_CORE_CTRL, 8'h00);
    m2 = 8'h00;
    m3 = 8'h00;
    wr(pir_pkg::OFF_REQ_TWO, m2);
    wr(pir_pkg::OFF_REQ_THREE, m3);
    for (int n = 0; n < 150; n++) begin
      e = 10'($urandom) & 10'($urandom);
      pulse(e);
      m2 = m2 | two_of(e);
      m3 = m3 | three_of(e);
      if ($urandom % 3 == 0) begin
        d = 8'($urandom);
        wr(pir_pkg::OFF_REQ_TWO, d);
        m2 = d & 8'hf9;
        d = 8'($urandom);
        wr(pir_pkg::OFF_REQ_THREE, d);
        m3 = d & 8'h3a;
      end
      rd(pir_pkg::OFF_REQ_TWO, got);
      chk(got, m2);
      rd(pir_pkg::OFF_REQ_THREE, got);
      chk(got, m3);
    end
    // Frozen clock enable ignores events and writes
    @(posedge clk);
    ce <= 1'b0;
    pulse(10'h3ff);
    wr(pir_pkg::OFF_REQ_TWO, 8'hff);
    @(posedge clk);
    ce <= 1'b1;
    rd(pir_pkg::OFF_REQ_TWO, got);
    chk(got, m2);
    rd(pir_pkg::OFF_REQ_THREE, got);
    chk(got, m3);
    // Any reset clears every flag
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(pir_pkg::OFF_REQ_TWO, got);
    chk(got, 8'h00);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, periphIrq}, 8'h00);
    rd(pir_pkg::OFF_REQ_THREE, got);
    chk(got, 8'h00);
    report_and_stop();
  end
endmodule
